// file: include/xrm_pkg.sv
package xrm_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned RATE_INT_HZ = 48_000;
  localparam int unsigned RATE_MIN_HZ = 32_000;
  localparam int unsigned TICK_CYC = CLK_HZ / RATE_INT_HZ;
  localparam int unsigned PER_MIN_CYC = CLK_HZ / RATE_INT_HZ;
  localparam int unsigned PER_MAX_CYC = CLK_HZ / RATE_MIN_HZ;
  localparam int unsigned LOCK_TOL_CYC = 16;
  localparam logic [7:0] COEF_RATE_KHZ = 8'h30;
  localparam logic [4:0] IN_EQ_BANDS = 5'h08;
  localparam logic [4:0] EQA_BANDS = 5'h10;
  localparam logic [4:0] NO_EQ_BANDS = 5'h00;
  localparam logic [2:0] OUT_EQ_BANDS = 3'h5;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FILT_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h1c;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_POST = 3;
  localparam int unsigned CTRL_GANG = 4;
  localparam int unsigned CTRL_EQA = 5;
  localparam int unsigned CTRL_AUX5 = 6;
  localparam int unsigned CTRL_AUX6 = 7;
  localparam int unsigned CTRL_ROUTE_LSB = 8;
  localparam int unsigned FILT_HP_LSB = 0;
  localparam int unsigned FILT_LP_LSB = 3;
  localparam int unsigned STAT_LOCK = 0;
  localparam int unsigned STAT_OFFER = 1;
  localparam int unsigned STAT_MTR_A_LSB = 4;
  localparam int unsigned STAT_MTR_B_LSB = 8;
  localparam int unsigned STAT_HP6_LSB = 16;
  localparam int unsigned STAT_LP6_LSB = 24;
  localparam logic [5:0] FILT_RST = 6'h00;
  localparam logic [23:0] THR_M24 = 24'h08138c;
  localparam logic [23:0] THR_M12 = 24'h202750;
  localparam logic [23:0] THR_M6 = 24'h4026e7;
  localparam logic [23:0] THR_CLIP = 24'h5a9df7;
  localparam int unsigned HOLD_TICKS = 2400;

  typedef enum logic [2:0]
  {
    XRM_M2X2 = 3'b000,
    XRM_M2X3 = 3'b001,
    XRM_M4P2 = 3'b011,
    XRM_M5P1 = 3'b010,
    XRM_M6 = 3'b110
  } xrm_mode_t;

  typedef enum logic [1:0]
  {
    route_analog_to_analog = 2'b00,
    route_analog_to_digital = 2'b01,
    route_digital_to_analog = 2'b10,
    route_digital_to_digital = 2'b11
  } xrm_route_t;

  typedef enum logic [1:0]
  {
    src_a = 2'b00,
    src_b = 2'b01,
    src_sum = 2'b11
  } xrm_src_t;

  typedef enum logic [2:0]
  {
    flt_bes12 = 3'h0,
    flt_bes18 = 3'h1,
    flt_bes24 = 3'h2,
    flt_btw12 = 3'h3,
    flt_btw18 = 3'h4,
    flt_btw24 = 3'h5,
    flt_lr24 = 3'h6
  } xrm_flt_t;

  function automatic logic xrm_mode_ok(logic [2:0] m);
    return m inside {XRM_M2X2, XRM_M2X3, XRM_M4P2, XRM_M5P1, XRM_M6};
  endfunction : xrm_mode_ok

  function automatic logic xrm_tap_offered(xrm_mode_t m, logic aux5, logic aux6);
    return (m == XRM_M2X2) || (m == XRM_M4P2 && (aux5 || aux6)) || (m == XRM_M5P1 && aux6);
  endfunction : xrm_tap_offered

  function automatic logic xrm_eqa_ok(xrm_mode_t m);
    return m inside {XRM_M4P2, XRM_M5P1, XRM_M6};
  endfunction : xrm_eqa_ok

  function automatic xrm_src_t xrm_src_of(xrm_mode_t m, logic [2:0] idx, logic aux5, logic aux6);
    xrm_src_t s;
    s = src_a;
    case (m)
      XRM_M2X2: s = (idx < 3'd2) ? src_a : ((idx < 3'd4) ? src_b : src_sum);
      XRM_M2X3: s = (idx < 3'd3) ? src_a : src_b;
      XRM_M4P2:
      begin
        if (idx < 3'd4)
          s = src_a;
        else if (idx == 3'd4)
          s = aux5 ? src_sum : src_b;
        else
          s = aux6 ? src_sum : src_b;
      end
      XRM_M5P1: s = (idx < 3'd5) ? src_a : (aux6 ? src_sum : src_b);
      default: s = src_a;
    endcase
    return s;
  endfunction : xrm_src_of
endpackage : xrm_pkg

// file: src/xrm_clip_meter.sv
`timescale 1ns/1ps
module xrm_clip_meter (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic [23:0] sample,
  input wire logic dig_clip,
  output logic [3:0] meter
);
  import xrm_pkg::*;

  typedef struct packed {
    logic [3:0] meter;
    logic [11:0] hold;
  } xrm_mtr_t;

  xrm_mtr_t q;
  xrm_mtr_t d;
  logic [23:0] mag;
  logic [3:0] now;

  always_comb
  begin
    d = q;
    mag = sample[23] ? ~sample : sample;
    // clip step lights 3 dB early so the red still leaves margin
    now = {mag >= THR_CLIP, mag >= THR_M6, mag >= THR_M12, mag >= THR_M24};
    if (dig_clip)
      now = 4'h8;
    if (tick)
    begin
      if (q.hold == 12'h000 || dig_clip)
      begin
        d.meter = now;
        d.hold = (|now) ? 12'(HOLD_TICKS) : 12'h000;
      end
      else
      begin
        d.meter = q.meter[3] && !q.meter[2] ? q.meter : (q.meter | now);
        d.hold = q.hold - 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign meter = q.meter;
endmodule : xrm_clip_meter

// file: src/xrm_sat_add.sv
`timescale 1ns/1ps
module xrm_sat_add #(
  parameter int W = 24
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] sum,
  output logic ovf
);
  logic [W:0] raw;

  always_comb
  begin
    raw = {a[W-1], a} + {b[W-1], b};
    ovf = raw[W] ^ raw[W-1];
    // clip to full scale rather than wrap, a wrapped sum would slam the speakers
    if (ovf)
      sum = raw[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    else
      sum = raw[W-1:0];
  end
endmodule : xrm_sat_add

// file: src/xrm_top.sv
// Behaviour
// - two-by-two mode: A feeds outputs 1 low, 2 high; B feeds 3 low, 4 high.
// - two-by-two mode: outputs 5 and 6 take the A+B sum, 5 as sub.
// - sum tap pre or post input eq; toggling leaves filter settings untouched.
// - two-by-three mode: A feeds outputs 1-3, B feeds outputs 4-6.
// - ganging links pairs 1/4, 2/5, 3/6; a change on one hits both.
// - four-plus-two mode: A feeds 1-4; outputs 5, 6 take B or sum.
// - four-plus-two: tap choice offered only when output 5 or 6 uses sum.
// - four, five and six way modes may move all sixteen eq bands to A.
// - five-plus-one: A feeds 1-5; output 6 takes B or sum, tap if sum.
// - six way mode: A feeds all six outputs, lowest sub at output 1.
// - with digital option, four routes: analog/digital in to analog/digital out.
// - input A always analog; input B analog or digital stereo per route.
// - digital out: connectors 1-3 carry channel pairs 1&2, 3&4, 5&6.
// - connectors 4-6 always carry only their own analog channel.
// - processing runs at 48 kHz; analog-in digital-out fixed at 48 kHz.
// - digital input locks to 32 to 48 kHz; output uses that rate.
// - coefficients and delays always assume 48 kHz, no rate compensation.
// - meter shows clip 3 dB before true clipping.
// - digital clipping lights top meter step alone.
// - high and low pass set apart: bessel/butterworth 12-24, or lr24.
// - turnover reported at -3 dB, except lr24 reported at -6 dB.
// - each output five eq bands, delay, limiter, invert; inputs eight eq bands.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module xrm_top #(
  parameter int W = 24,
  parameter bit AES_FITTED = 1'b1,
  parameter int unsigned TICK_CYC_P = xrm_pkg::TICK_CYC,
  parameter int unsigned PER_MIN_P = xrm_pkg::PER_MIN_CYC,
  parameter int unsigned PER_MAX_P = xrm_pkg::PER_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [xrm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [W-1:0] a_pre,
  input wire logic [W-1:0] a_post,
  input wire logic [W-1:0] b_pre,
  input wire logic [W-1:0] b_post,
  input wire logic [W-1:0] b_dig,
  input wire logic b_dig_valid,
  output logic [5:0][W-1:0] out_ch,
  output logic out_valid,
  output logic [2:0] conn_dig_en,
  output logic b_dig_sel,
  output logic rate_locked,
  output logic [7:0] coef_rate_khz,
  output logic [5:0][5:0] filt_cfg,
  output logic [5:0] hp_at_6db,
  output logic [5:0] lp_at_6db,
  output logic [4:0] eq_bands_a,
  output logic [4:0] eq_bands_b,
  output logic [2:0] out_eq_bands,
  output logic [3:0] meter_a,
  output logic [3:0] meter_b
);
  import xrm_pkg::*;

  typedef struct packed {
    xrm_mode_t mode;
    logic post;
    logic gang;
    logic eqa;
    logic aux5;
    logic aux6;
    xrm_route_t route;
    logic [5:0][5:0] filt;
    logic [5:0] hp6;
    logic [5:0] lp6;
    logic [5:0][W-1:0] outs;
    logic out_valid;
    logic [15:0] div;
    logic [15:0] per;
    logic locked;
    logic [31:0] rdata;
    logic [4:0] eq_a;
    logic [4:0] eq_b;
  } xrm_state_t;

  xrm_state_t q;
  xrm_state_t d;
  logic [W-1:0] b_pre_sel;
  logic [W-1:0] sum_pre;
  logic [W-1:0] sum_post;
  logic ovf_pre;
  logic ovf_post;
  logic tick;
  logic int_tick;
  logic dig_in;
  logic [3:0] mtr_a;
  logic [3:0] mtr_b;

  assign dig_in = q.route[1];
  // digital stream replaces analog B only on digital-in routes
  assign b_pre_sel = dig_in ? b_dig : b_pre;
  assign int_tick = (q.div == 16'(TICK_CYC_P - 1));
  // unlocked digital input falls back to the internal rate rather than stall
  assign tick = (dig_in && q.locked) ? b_dig_valid : int_tick;

  xrm_sat_add #(.W(W)) u_sum_pre (
    .a(a_pre),
    .b(b_pre_sel),
    .sum(sum_pre),
    .ovf(ovf_pre)
  );

  xrm_sat_add #(.W(W)) u_sum_post (
    .a(a_post),
    .b(b_post),
    .sum(sum_post),
    .ovf(ovf_post)
  );

  xrm_clip_meter u_mtr_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .sample(a_post[W-1 -: 24]),
    .dig_clip(q.post ? ovf_post : ovf_pre),
    .meter(mtr_a)
  );

  xrm_clip_meter u_mtr_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .sample(b_post[W-1 -: 24]),
    .dig_clip(q.post ? ovf_post : ovf_pre),
    .meter(mtr_b)
  );

  always_comb
  begin
    logic [2:0] idx;
    logic [2:0] pair;
    logic [5:0] val;
    xrm_src_t s;
    idx = 3'h0;
    pair = 3'h0;
    val = 6'h00;
    s = src_a;
    d = q;
    d.out_valid = 1'b0;
    d.rdata = 32'h0000_0000;
    d.div = int_tick ? 16'h0000 : q.div + 16'h0001;
    // lock window on the measured frame period, with slack for jitter
    if (b_dig_valid)
    begin
      d.per = 16'h0000;
      d.locked = (q.per >= 16'(PER_MIN_P - LOCK_TOL_CYC))
        && (q.per <= 16'(PER_MAX_P + LOCK_TOL_CYC));
    end
    else if (q.per > 16'(PER_MAX_P + LOCK_TOL_CYC))
      d.locked = 1'b0;
    else
      d.per = q.per + 16'h0001;
    if (reg_wr && reg_addr == CTRL_OFS)
    begin
      if (xrm_mode_ok(reg_wdata[CTRL_MODE_LSB +: 3]))
        d.mode = xrm_mode_t'(reg_wdata[CTRL_MODE_LSB +: 3]);
      d.aux5 = reg_wdata[CTRL_AUX5];
      d.aux6 = reg_wdata[CTRL_AUX6];
      d.post = reg_wdata[CTRL_POST];
      d.gang = reg_wdata[CTRL_GANG];
      d.eqa = reg_wdata[CTRL_EQA];
      d.route = AES_FITTED ? xrm_route_t'(reg_wdata[CTRL_ROUTE_LSB +: 2])
        : route_analog_to_analog;
    end
    // the tap bit lives apart from the filter bank, so flipping it leaves eq alone
    d.post = d.post && xrm_tap_offered(d.mode, d.aux5, d.aux6);
    d.gang = d.gang && (d.mode == XRM_M2X2 || d.mode == XRM_M2X3);
    d.eqa = d.eqa && xrm_eqa_ok(d.mode);
    d.eq_a = d.eqa ? EQA_BANDS : IN_EQ_BANDS;
    d.eq_b = d.eqa ? NO_EQ_BANDS : IN_EQ_BANDS;
    if (reg_wr && reg_addr >= FILT_OFS && reg_addr < STAT_OFS && reg_addr[1:0] == 2'b00)
    begin
      idx = 3'(8'(reg_addr - FILT_OFS) >> 2);
      pair = (idx < 3'd3) ? idx + 3'd3 : idx - 3'd3;
      val = q.filt[idx];
      // undefined slope codes are dropped, the section keeps its last shape
      if (reg_wdata[FILT_HP_LSB +: 3] <= flt_lr24)
        val[FILT_HP_LSB +: 3] = reg_wdata[FILT_HP_LSB +: 3];
      if (reg_wdata[FILT_LP_LSB +: 3] <= flt_lr24)
        val[FILT_LP_LSB +: 3] = reg_wdata[FILT_LP_LSB +: 3];
      d.filt[idx] = val;
      if (q.gang)
        d.filt[pair] = val;
    end
    for (int i = 0; i < 6; i++)
    begin
      d.hp6[i] = (d.filt[i][FILT_HP_LSB +: 3] == flt_lr24);
      d.lp6[i] = (d.filt[i][FILT_LP_LSB +: 3] == flt_lr24);
    end
    if (tick)
    begin
      d.out_valid = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
        s = xrm_src_of(q.mode, 3'(i), q.aux5, q.aux6);
        case (s)
          src_a: d.outs[i] = a_post;
          src_b: d.outs[i] = b_post;
          src_sum: d.outs[i] = q.post ? sum_post : sum_pre;
          default: d.outs[i] = a_post;
        endcase
      end
    end
    if (reg_rd)
    begin
      if (reg_addr == CTRL_OFS)
      begin
        d.rdata[CTRL_MODE_LSB +: 3] = q.mode;
        d.rdata[CTRL_POST] = q.post;
        d.rdata[CTRL_GANG] = q.gang;
        d.rdata[CTRL_EQA] = q.eqa;
        d.rdata[CTRL_AUX5] = q.aux5;
        d.rdata[CTRL_AUX6] = q.aux6;
        d.rdata[CTRL_ROUTE_LSB +: 2] = q.route;
      end
      else if (reg_addr >= FILT_OFS && reg_addr < STAT_OFS && reg_addr[1:0] == 2'b00)
        d.rdata[5:0] = q.filt[3'(8'(reg_addr - FILT_OFS) >> 2)];
      else if (reg_addr == STAT_OFS)
      begin
        d.rdata[STAT_LOCK] = q.locked;
        d.rdata[STAT_OFFER] = xrm_tap_offered(q.mode, q.aux5, q.aux6);
        d.rdata[STAT_MTR_A_LSB +: 4] = mtr_a;
        d.rdata[STAT_MTR_B_LSB +: 4] = mtr_b;
        d.rdata[STAT_HP6_LSB +: 6] = q.hp6;
        d.rdata[STAT_LP6_LSB +: 6] = q.lp6;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.mode <= XRM_M2X2;
      q.route <= route_analog_to_analog;
      q.eq_a <= IN_EQ_BANDS;
      q.eq_b <= IN_EQ_BANDS;
      for (int i = 0; i < 6; i++)
        q.filt[i] <= FILT_RST;
    end
    else
      q <= d;
  end

  assign reg_rdata = q.rdata;
  assign out_ch = q.outs;
  assign out_valid = q.out_valid;
  // channel pairs ride connectors 1-3; connectors 4-6 have no digital lane at all
  assign conn_dig_en = {3{q.route[0]}};
  assign b_dig_sel = q.route[1];
  assign rate_locked = q.locked;
  // no rescaling at other rates, so filter points slide by the rate ratio
  assign coef_rate_khz = COEF_RATE_KHZ;
  assign filt_cfg = q.filt;
  assign hp_at_6db = q.hp6;
  assign lp_at_6db = q.lp6;
  assign eq_bands_a = q.eq_a;
  assign eq_bands_b = q.eq_b;
  assign out_eq_bands = OUT_EQ_BANDS;
  assign meter_a = mtr_a;
  assign meter_b = mtr_b;
endmodule : xrm_top

// file: test/tb_xrm_top.sv
`timescale 1ns/1ps
module tb_xrm_top;
  import xrm_pkg::*;
  typedef struct packed {logic [9:0] ctrl; logic [11:0] src; logic post; logic offer;} xrm_row_t;
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [23:0] a_pre = 24'h000100, a_post = 24'h000200, b_pre = 24'h000030, b_post = 24'h000040;
  logic [23:0] b_dig;
  logic b_dig_valid, out_valid, b_dig_sel, rate_locked;
  logic [5:0][23:0] out_ch;
  logic [2:0] conn_dig_en, out_eq_bands;
  logic [7:0] coef_rate_khz;
  logic [5:0][5:0] filt_cfg;
  logic [5:0] hp_at_6db, lp_at_6db;
  logic [4:0] eq_bands_a, eq_bands_b;
  logic [3:0] meter_a, meter_b;
  int fails = 0, checked = 0;
  // src: two bits per output, 0 a, 1 b, 2 sum
  xrm_row_t rows [8] = '{'{10'h000, 12'ha50, 1'b0, 1'b1}, '{10'h008, 12'ha50, 1'b1, 1'b1},
    '{10'h001, 12'h540, 1'b0, 1'b0}, '{10'h04b, 12'h600, 1'b1, 1'b1},
    '{10'h00b, 12'h500, 1'b0, 1'b0}, '{10'h08a, 12'h800, 1'b1, 1'b1},
    '{10'h002, 12'h400, 1'b0, 1'b0}, '{10'h006, 12'h000, 1'b0, 1'b0}};
  always #2 core_clk = ~core_clk;
  xrm_aes_src #(.PER(30)) u_src (.core_clk(core_clk), .en(en), .b_dig_valid(b_dig_valid),
    .b_dig(b_dig));
  // short tick keeps the run small; lock window scales with it
  xrm_top #(.TICK_CYC_P(24), .PER_MIN_P(24), .PER_MAX_P(36)) uut (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .a_pre(a_pre), .a_post(a_post), .b_pre(b_pre),
    .b_post(b_post), .b_dig(b_dig), .b_dig_valid(b_dig_valid), .out_ch(out_ch),
    .out_valid(out_valid), .conn_dig_en(conn_dig_en), .b_dig_sel(b_dig_sel),
    .rate_locked(rate_locked), .coef_rate_khz(coef_rate_khz), .filt_cfg(filt_cfg),
    .hp_at_6db(hp_at_6db), .lp_at_6db(lp_at_6db), .eq_bands_a(eq_bands_a),
    .eq_bands_b(eq_bands_b), .out_eq_bands(out_eq_bands), .meter_a(meter_a), .meter_b(meter_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  // two frames so the first, possibly stale, sample is skipped
  task automatic wait_frame;
    int n;
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge core_clk);
        n++;
      end while (out_valid !== 1'b1 && n < 64);
      // a frame that never comes counts against the run
      chk(out_valid, 1'b1);
    end
    #1;
  endtask : wait_frame
  function automatic logic [23:0] exp_of(input logic [1:0] s, input logic post);
    case (s)
      2'd0: return a_post;
      2'd1: return b_post;
      default: return post ? a_post + b_post : a_pre + b_pre;
    endcase
  endfunction : exp_of
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial
  begin
    #100us;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int r = 0; r < 8; r++)
    begin
      wr(CTRL_OFS, {22'h0, rows[r].ctrl});
      wait_frame();
      for (int i = 0; i < 6; i++)
        chk(out_ch[i], exp_of(rows[r].src[2*i +: 2], rows[r].post));
      rd(STAT_OFS, d);
      chk(d[STAT_OFFER], rows[r].offer);
    end
    $display("mode rows done");
    wr(CTRL_OFS, 32'h011);
    wr(FILT_OFS, 32'h32);
    chk(filt_cfg[3], 6'h32);
    chk(lp_at_6db, 6'h09);
    wr(CTRL_OFS, 32'h001);
    wr(FILT_OFS + 8'h04, 32'h3f);
    chk(filt_cfg[1], 6'h00);
    wr(CTRL_OFS, 32'h008);
    chk(filt_cfg[0], 6'h32);
    $display("filter test done");
    wr(CTRL_OFS, 32'h026);
    chk(eq_bands_a, 5'h10);
    chk(eq_bands_b, 5'h00);
    wr(CTRL_OFS, 32'h020);
    chk(eq_bands_a, 5'h08);
    $display("eq test done");
    for (int r = 0; r < 4; r++)
    begin
      wr(CTRL_OFS, r << 8);
      chk(b_dig_sel, r[1]);
      chk(conn_dig_en, {3{r[0]}});
    end
    @(posedge core_clk);
    en <= 1'b1;
    wr(CTRL_OFS, 32'h200);
    repeat (150) @(posedge core_clk);
    #1;
    chk(rate_locked, 1'b1);
    // digital stream stands in for analog b in the pre-eq sum
    wait_frame();
    chk(out_ch[5], 24'h000150);
    @(posedge core_clk);
    en <= 1'b0;
    repeat (100) @(posedge core_clk);
    #1;
    chk(rate_locked, 1'b0);
    $display("route test done");
    wr(CTRL_OFS, 32'h000);
    @(posedge core_clk);
    a_post <= THR_CLIP;
    wait_frame();
    chk(meter_a, 4'hf);
    chk(meter_b, 4'h0);
    @(posedge core_clk);
    a_pre <= 24'h7fffff;
    b_pre <= 24'h7fffff;
    wait_frame();
    chk(out_ch[5], 24'h7fffff);
    chk(meter_a, 4'h8);
    chk(meter_b, 4'h8);
    rd(8'h80, d);
    chk(d, 32'h0);
    $display("saturation test done");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(filt_cfg[0], 6'h00);
    chk(filt_cfg[3], 6'h00);
    chk(meter_a, 4'h0);
    chk(eq_bands_a, 5'h08);
    rd(CTRL_OFS, d);
    chk(d, 32'h0);
    $display("reset test done");
    summarize();
  end
endmodule : tb_xrm_top
bind xrm_top xrm_top_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .out_valid(out_valid), .conn_dig_en(conn_dig_en),
  .b_dig_sel(b_dig_sel), .coef_rate_khz(coef_rate_khz), .filt_cfg(filt_cfg),
  .hp_at_6db(hp_at_6db), .lp_at_6db(lp_at_6db), .eq_bands_a(eq_bands_a),
  .eq_bands_b(eq_bands_b), .out_eq_bands(out_eq_bands));

// file: test/xrm_aes_src.sv
`timescale 1ns/1ps
module xrm_aes_src #(
  parameter int PER = 30
) (
  core_clk,
  en,
  b_dig_valid,
  b_dig
);
  input wire logic core_clk;
  input wire logic en;
  output logic b_dig_valid;
  output logic [23:0] b_dig;
  int cnt;
  initial
  begin
    cnt = 0;
    b_dig_valid = 1'b0;
    b_dig = 24'h0;
  end
  // frame period sits inside the lockable window
  always @(posedge core_clk)
  begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    b_dig_valid <= en && cnt == PER - 1;
    b_dig <= en ? 24'h000050 : ~b_dig; // idle line toggles so stale data never matches
  end
endmodule : xrm_aes_src

// file: test/xrm_top_asserts.sv
`timescale 1ns/1ps
module xrm_top_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [xrm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic out_valid,
  input wire logic [2:0] conn_dig_en,
  input wire logic b_dig_sel,
  input wire logic [7:0] coef_rate_khz,
  input wire logic [5:0][5:0] filt_cfg,
  input wire logic [5:0] hp_at_6db,
  input wire logic [5:0] lp_at_6db,
  input wire logic [4:0] eq_bands_a,
  input wire logic [4:0] eq_bands_b,
  input wire logic [2:0] out_eq_bands
);
  import xrm_pkg::*;
  logic [5:0] hp_lr;
  logic [5:0] lp_lr;
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      hp_lr[i] = filt_cfg[i][2:0] == 3'h6;
      lp_lr[i] = filt_cfg[i][5:3] == 3'h6;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_ctrl_wr;
    reg_wr && reg_addr == CTRL_OFS;
  endsequence
  sequence s_route_seen;
    b_dig_sel == $past(reg_wdata[9]) && conn_dig_en == {3{$past(reg_wdata[8])}};
  endsequence
  property p_route;
    s_ctrl_wr |=> s_route_seen;
  endproperty
  property p_conn;
    conn_dig_en == 3'h0 || conn_dig_en == 3'h7;
  endproperty
  property p_coef;
    coef_rate_khz == 8'h30;
  endproperty
  property p_out_eq;
    out_eq_bands == 3'h5;
  endproperty
  property p_eq_split;
    (eq_bands_a == 5'h08 && eq_bands_b == 5'h08) || (eq_bands_a == 5'h10 && eq_bands_b == 5'h00);
  endproperty
  property p_hp_turn;
    hp_at_6db == hp_lr;
  endproperty
  property p_lp_turn;
    lp_at_6db == lp_lr;
  endproperty
  property p_valid_pulse;
    out_valid |=> !out_valid;
  endproperty
  property p_unmapped;
    reg_rd && reg_addr == 8'h80 |=> reg_rdata == 32'h0;
  endproperty
  a_route: assert property (p_route) else $error("route outputs differ from ctrl write");
  a_conn: assert property (p_conn) else $error("connectors 1-3 not switched together");
  a_coef: assert property (p_coef) else $error("coefficient rate not 48");
  a_out_eq: assert property (p_out_eq) else $error("output eq band count wrong");
  a_eq_split: assert property (p_eq_split) else $error("input eq split wrong");
  a_hp_turn: assert property (p_hp_turn) else $error("hp turnover point flag wrong");
  a_lp_turn: assert property (p_lp_turn) else $error("lp turnover point flag wrong");
  a_valid_pulse: assert property (p_valid_pulse) else $error("out_valid too long");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : xrm_top_asserts
